/* File: rtl/io_cell_regs.vh */
/*
 * register offsets, field positions, reset values and timing counts of
 * the io_cell storage block.
 * assumes: included by bare name from the design files of the block.
 */
`ifndef IO_CELL_REGS_VH
`define IO_CELL_REGS_VH

// byte addresses on the register bus
`define ADDR_CTRL 8'h00
`define ADDR_POL 8'h04
`define ADDR_ELEM_BASE 8'h08
`define ADDR_ELEM_LAST 8'h1c
`define ADDR_STATUS 8'h20

// control register fields
`define CTRL_SYNC 0
`define CTRL_IN_DDR 1
`define CTRL_OUT_DDR 2
`define CTRL_TRI_DDR 3
`define CTRL_MIRROR 4
`define CTRL_FALL 5
`define CTRL_INIT 6
`define CTRL_IN_CE_USED 8
`define CTRL_OUT_CE_USED 9
`define CTRL_TRI_CE_USED 10
`define CTRL_W 11
`define CTRL_RST 11'h000

// polarity register fields, 1 inverts the control input
`define POL_IN_CE 0
`define POL_OUT_CE 1
`define POL_TRI_CE 2
`define POL_SR 3
`define POL_REVERSE 4
`define POL_W 5
`define POL_RST 5'h00

// per storage element configuration fields
`define ELEM_LATCH 0
`define ELEM_FORCE_HIGH 1
`define ELEM_INIT_ONE 2
`define ELEM_SET_EN 3
`define ELEM_RST_EN 4
`define ELEM_W 5
`define ELEM_RST 5'h00
`define ELEM_COUNT 6

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// synchroniser depth in front of pin and clock-net inputs
`define SYNC_STAGES 2

`endif

/* File: rtl/clk_net_sync.v */
/*
 * two-stage synchroniser with active-level and active-edge outputs.
 * assumes: raw_in is asynchronous to aclk; invert comes from aclk logic.
 */
`timescale 1ns/1ps
module clk_net_sync (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // raw asynchronous level
   input wire raw_in,
   // 1 makes the low level the active one
   input wire invert,
   // synchronised results
   output wire level,
   output wire edge_pulse
);
   reg meta_q;
   reg sync_q;
   reg prev_q;

   // two flops, then a history flop for edge detection
   always @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= raw_in;
         sync_q <= meta_q;
         prev_q <= sync_q ^ invert;
      end
   end

   // active level and its rising moment
   assign level = sync_q ^ invert;
   assign edge_pulse = level & ~prev_q;
endmodule // clk_net_sync

/* File: rtl/storage_element.v */
/*
 * one storage element of the io_cell: flip-flop or transparent latch
 * with set, reset and init forcing, all emulated on aclk.
 * assumes: trig_edge and trig_level derive from a synchronised clock net.
 */
`timescale 1ns/1ps
module storage_element (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // mode
   input wire latch_mode,
   input wire sync_mode,
   // cell clock net events
   input wire trig_edge,
   input wire trig_level,
   // data and enable
   input wire ce,
   input wire d,
   // forcing inputs, already polarity corrected and gated
   input wire set_in,
   input wire rst_in,
   input wire init_pulse,
   input wire init_val,
   // stored value
   output reg q
);
   wire trig;

   // flip-flop takes the edge, latch is open for the whole level
   assign trig = latch_mode ? trig_level : trig_edge;

   // priority: init, async clear, async preset, then clocked behaviour
   always @(posedge aclk) begin
      if (!aresetn) begin
         q <= 1'b0;
      end else if (init_pulse) begin
         q <= init_val;
      end else if (!sync_mode && rst_in) begin
         q <= 1'b0;
      end else if (!sync_mode && set_in) begin
         q <= 1'b1;
      end else if (trig) begin
         if (sync_mode && rst_in) begin
            q <= 1'b0;
         end else if (sync_mode && set_in) begin
            q <= 1'b1;
         end else if (ce) begin
            q <= d;
         end
      end
   end
endmodule // storage_element

/* File: rtl/io_cell_ddr_storage.v */
/*
 * storage logic of one programmable io_cell: input, output and
 * tri-state paths, two storage elements each, with an AXI4-Lite slave
 * holding the configuration attributes and showing element state.
 * assumes: the two clock nets are free-running, 180 degrees apart and
 * much slower than aclk; pin and clock nets are asynchronous to aclk;
 * fabric data and control inputs are on aclk.
 */
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "io_cell_regs.vh"

// Function
// - six storage elements, two per input, output and tri-state path.
// - each element works as edge flip-flop or transparent latch.
// - pair uses same edge of two clock nets 180 degrees apart.
// - ddr output and tri-state paths alternate their two registers.
// - output pair can mirror the clock through the same structure.
// - each register pair has its own clock enable.
// - enables active high by default; unconnected enable counts as active.
// - set/reset input forces configured value, one or zero.
// - reverse input forces the opposite of the configured value.
// - reset wins over set, synchronous and asynchronous alike.
// - after init each element takes its init value.
// - attributes per element; sync or async choice for whole cell.
// - every control input has its own selectable polarity.
// - seven set/reset configurations, none through async both.
module io_cell_ddr_storage (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   // register bus write address
   input wire [7:0] s_axi_awaddr,
   input wire [2:0] s_axi_awprot,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // register bus write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // register bus write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // register bus read
   input wire [7:0] s_axi_araddr,
   input wire [2:0] s_axi_arprot,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // two cell clock nets, 180 degrees apart
   input wire clk_net0,
   input wire clk_net180,
   // fabric side data
   input wire out_d0,
   input wire out_d1,
   input wire tri_d0,
   input wire tri_d1,
   output wire in_q0,
   output wire in_q1,
   // fabric side controls
   input wire input_pair_clk_en,
   input wire output_pair_clk_en,
   input wire tristate_pair_clk_en,
   input wire set_reset_in,
   input wire reverse_force_in,
   // package pin
   input wire pin_i,
   output wire pin_o,
   output wire pin_oe
);
   // configuration state
   reg [`CTRL_W-1:0] ctrl_q;
   reg [`POL_W-1:0] pol_q;
   reg [`ELEM_W-1:0] elem_cfg_q [0:`ELEM_COUNT-1];
   reg init_q;
   // write channel holding state
   reg aw_full_q;
   reg [7:0] aw_addr_q;
   reg w_full_q;
   reg [31:0] w_data_q;
   reg [3:0] w_strb_q;
   // synchronised nets
   wire lvl0, lvl180, edge0, edge180, pin_sync;
   // per element wiring
   reg [`ELEM_COUNT-1:0] e_d, e_ce, e_set, e_rst, e_edge, e_lvl;
   wire [`ELEM_COUNT-1:0] e_q;
   // polarity corrected controls
   wire in_ce, out_ce, tri_ce, sr, reverse_act;
   wire do_write;
   wire [31:0] ctrl_wr, pol_wr;
   integer k;
   integer j;

   // byte-lane merge of a write into a stored word
   function [31:0] merge;
      input [31:0] old;
      input [31:0] data;
      input [3:0] strb;
      integer b;
      begin
         merge = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (strb[b]) begin
               merge[8*b +: 8] = data[8*b +: 8];
            end
         end
      end
   endfunction

   // element index of a configuration address, 7 when not one
   function [2:0] elem_index;
      input [7:0] addr;
      reg [7:0] off;
      begin
         off = addr - `ADDR_ELEM_BASE;
         if (addr >= `ADDR_ELEM_BASE && addr <= `ADDR_ELEM_LAST &&
             addr[1:0] == 2'h0) begin
            elem_index = off[4:2];
         end else begin
            elem_index = 3'h7;
         end
      end
   endfunction

   // clock nets share one edge type chosen in ctrl
   clk_net_sync u_sync0 (
      .aclk(aclk),
      .aresetn(aresetn),
      .raw_in(clk_net0),
      .invert(ctrl_q[`CTRL_FALL]),
      .level(lvl0),
      .edge_pulse(edge0)
   );

   clk_net_sync u_sync180 (
      .aclk(aclk),
      .aresetn(aresetn),
      .raw_in(clk_net180),
      .invert(ctrl_q[`CTRL_FALL]),
      .level(lvl180),
      .edge_pulse(edge180)
   );

   clk_net_sync u_sync_pin (
      .aclk(aclk),
      .aresetn(aresetn),
      .raw_in(pin_i),
      .invert(1'b0),
      .level(pin_sync),
      .edge_pulse()
   );

   // control polarity, and unconnected enables held active
   assign in_ce = ~ctrl_q[`CTRL_IN_CE_USED] |
                (input_pair_clk_en ^ pol_q[`POL_IN_CE]);
   assign out_ce = ~ctrl_q[`CTRL_OUT_CE_USED] |
                (output_pair_clk_en ^ pol_q[`POL_OUT_CE]);
   assign tri_ce = ~ctrl_q[`CTRL_TRI_CE_USED] |
                (tristate_pair_clk_en ^ pol_q[`POL_TRI_CE]);
   assign sr = set_reset_in ^ pol_q[`POL_SR];
   assign reverse_act = reverse_force_in ^ pol_q[`POL_REVERSE];

   // route data, enables, clock events and forcing to each element
   always @* begin
      e_d[0] = pin_sync;
      e_d[1] = pin_sync;
      e_d[2] = ctrl_q[`CTRL_MIRROR] ? 1'b1 : out_d0;
      e_d[3] = ctrl_q[`CTRL_MIRROR] ? 1'b0 : out_d1;
      e_d[4] = tri_d0;
      e_d[5] = tri_d1;
      e_ce[0] = in_ce;
      e_ce[1] = in_ce;
      e_ce[2] = out_ce;
      e_ce[3] = out_ce;
      e_ce[4] = tri_ce;
      e_ce[5] = tri_ce;
      for (k = 0; k < `ELEM_COUNT; k = k + 1) begin
         // even elements on net 0, odd ones on net 180
         e_edge[k] = k[0] ? edge180 : edge0;
         e_lvl[k] = k[0] ? lvl180 : lvl0;
         // sr drives the configured value, rev the opposite one
         if (elem_cfg_q[k][`ELEM_FORCE_HIGH]) begin
            e_set[k] = sr & elem_cfg_q[k][`ELEM_SET_EN];
            e_rst[k] = reverse_act & elem_cfg_q[k][`ELEM_RST_EN];
         end else begin
            e_set[k] = reverse_act & elem_cfg_q[k][`ELEM_SET_EN];
            e_rst[k] = sr & elem_cfg_q[k][`ELEM_RST_EN];
         end
      end
   end

   // six storage elements, attributes independent per element
   genvar g;
   generate
      for (g = 0; g < `ELEM_COUNT; g = g + 1) begin : g_elem
         storage_element u_elem (
            .aclk(aclk),
            .aresetn(aresetn),
            .latch_mode(elem_cfg_q[g][`ELEM_LATCH]),
            .sync_mode(ctrl_q[`CTRL_SYNC]),
            .trig_edge(e_edge[g]),
            .trig_level(e_lvl[g]),
            .ce(e_ce[g]),
            .d(e_d[g]),
            .set_in(e_set[g]),
            .rst_in(e_rst[g]),
            .init_pulse(init_q),
            .init_val(elem_cfg_q[g][`ELEM_INIT_ONE]),
            .q(e_q[g])
         );
      end
   endgenerate

   // input pair to fabric, second register only used in ddr mode
   assign in_q0 = e_q[0];
   assign in_q1 = ctrl_q[`CTRL_IN_DDR] ? e_q[1] : e_q[0];

   // ddr paths alternate registers with the active clock net
   assign pin_o = (ctrl_q[`CTRL_OUT_DDR] && !lvl0) ?
                  e_q[3] : e_q[2];
   assign pin_oe = ~((ctrl_q[`CTRL_TRI_DDR] && !lvl0) ?
                  e_q[5] : e_q[4]);

   // bus handshakes
   assign s_axi_awready = ~aw_full_q & ~s_axi_bvalid;
   assign s_axi_wready = ~w_full_q & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign do_write = aw_full_q & w_full_q & ~s_axi_bvalid;

   // register images after a byte-lane merge of the pending write
   assign ctrl_wr = merge({21'h000000, ctrl_q}, w_data_q, w_strb_q);
   assign pol_wr = merge({27'h0000000, pol_q}, w_data_q, w_strb_q);

   // write side: address and data in either order, then response
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_full_q <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr_q == `ADDR_CTRL || aw_addr_q == `ADDR_POL ||
                aw_addr_q == `ADDR_STATUS ||
                elem_index(aw_addr_q) != 3'h7) begin
               s_axi_bresp <= `RESP_OKAY;
            end else begin
               s_axi_bresp <= `RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // configuration registers; init runs once after reset or on request
   always @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= `CTRL_RST;
         pol_q <= `POL_RST;
         init_q <= 1'b1;
         for (j = 0; j < `ELEM_COUNT; j = j + 1) begin
            elem_cfg_q[j] <= `ELEM_RST;
         end
      end else begin
         init_q <= 1'b0;
         if (do_write) begin
            if (aw_addr_q == `ADDR_CTRL) begin
               ctrl_q <= ctrl_wr[`CTRL_W-1:0] & 11'h73f;
               init_q <= w_strb_q[0] & w_data_q[`CTRL_INIT];
            end
            if (aw_addr_q == `ADDR_POL) begin
               pol_q <= pol_wr[`POL_W-1:0];
            end
            for (j = 0; j < `ELEM_COUNT; j = j + 1) begin
               if (elem_index(aw_addr_q) == j[2:0]) begin
                  elem_cfg_q[j] <= w_strb_q[0] ? w_data_q[`ELEM_W-1:0] :
                     elem_cfg_q[j];
               end
            end
         end
      end
   end

   // read side: one cycle from address to data
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= `RESP_OKAY;
         s_axi_rdata <= 32'h0000_0000;
         if (s_axi_araddr == `ADDR_CTRL) begin
            s_axi_rdata <= {21'h000000, ctrl_q};
         end else if (s_axi_araddr == `ADDR_POL) begin
            s_axi_rdata <= {27'h0000000, pol_q};
         end else if (s_axi_araddr == `ADDR_STATUS) begin
            s_axi_rdata <= {20'h00000, lvl180, lvl0, pin_sync, pin_oe,
                            pin_o, 1'b0, e_q};
         end else if (elem_index(s_axi_araddr) != 3'h7) begin
            s_axi_rdata <= {27'h0000000,
                            elem_cfg_q[elem_index(s_axi_araddr)]};
         end else begin
            s_axi_rresp <= `RESP_SLVERR;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // io_cell_ddr_storage

/* File: verification/io_pin_partner.sv */
/*
 * far-side device on the io_cell package pin.
 * assumes: the bench raises drv_en only while the cell has released it.
 */
`timescale 1ns/1ps
module io_pin_partner (
   // cell side of the pin
   input logic pin_o,
   input logic pin_oe,
   // far-side drive request
   input logic drv_en,
   input logic drv_val,
   // resolved pin level
   output logic pin_i = 1'b0
);
   // cell drive wins; a pin nobody drives shows its last level inverted
   always @(pin_o or pin_oe or drv_en or drv_val) begin
      if (pin_oe === 1'b1)
         pin_i = pin_o;
      else if (drv_en === 1'b1)
         pin_i = drv_val;
      else
         pin_i = ~pin_i;
   end
endmodule // io_pin_partner

/* File: verification/io_cell_ddr_storage_monitor.sv */
/*
 * port checker for io_cell_ddr_storage: bus handshakes, reset pins.
 * assumes: bound to the top module; one clock, synchronous reset.
 */
`timescale 1ns/1ps
`include "io_cell_regs.vh"
module io_cell_ddr_storage_monitor (
   // clock and reset
   input logic aclk,
   input logic aresetn,
   // register bus
   input logic s_axi_awvalid,
   input logic s_axi_awready,
   input logic s_axi_wvalid,
   input logic s_axi_wready,
   input logic [1:0] s_axi_bresp,
   input logic s_axi_bvalid,
   input logic s_axi_bready,
   input logic s_axi_arvalid,
   input logic s_axi_arready,
   input logic [1:0] s_axi_rresp,
   input logic s_axi_rvalid,
   input logic s_axi_rready,
   // pin
   input logic pin_o,
   input logic pin_oe
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // answers and refusals of the register bus
   property p_w_answer;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> ##2 s_axi_bvalid;
   endproperty
   a_w_answer: assert property (p_w_answer)
      else $error("no write response after write taken");
   property p_r_answer;
      s_axi_arvalid && s_axi_arready |-> ##1 s_axi_rvalid;
   endproperty
   a_r_answer: assert property (p_r_answer)
      else $error("no read data after read taken");
   property p_b_once;
      $fell(s_axi_bvalid) |-> $past(s_axi_bready);
   endproperty
   a_b_once: assert property (p_b_once)
      else $error("bvalid dropped without bready");
   property p_r_once;
      s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
   endproperty
   a_r_once: assert property (p_r_once)
      else $error("rvalid stayed after read taken");
   property p_aw_block;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_aw_block: assert property (p_aw_block)
      else $error("write accepted while response pending");
   property p_ar_free;
      s_axi_arready == !s_axi_rvalid;
   endproperty
   a_ar_free: assert property (p_ar_free)
      else $error("arready not the inverse of rvalid");
   property p_w_again;
      s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready;
   endproperty
   a_w_again: assert property (p_w_again)
      else $error("write channels not ready after response");
   property p_rresp_code;
      s_axi_rvalid |-> s_axi_rresp inside {`RESP_OKAY, `RESP_SLVERR};
   endproperty
   a_rresp_code: assert property (p_rresp_code)
      else $error("read response code out of set");
   property p_init_pins;
      $rose(aresetn) |-> pin_oe && !pin_o;
   endproperty
   a_init_pins: assert property (p_init_pins)
      else $error("pin not driven low after reset");

   // main scenarios reached
   c_w_err: cover property (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);
   c_r_err: cover property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR);
   c_oe_off: cover property ($fell(pin_oe));
endmodule // io_cell_ddr_storage_monitor

bind io_cell_ddr_storage io_cell_ddr_storage_monitor mon (.aclk, .aresetn,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_o,
   .pin_oe);

/* File: verification/io_cell_ddr_storage_tb_top.sv */
/*
 * self-checking bench for io_cell_ddr_storage.
 * assumes: the design, its register header, partner and checker.
 */
`timescale 1ns/1ps
`include "io_cell_regs.vh"
module io_cell_ddr_storage_tb_top;
   // bench signals
   logic aclk = 0, aresetn = 0, clk_net0 = 0, clk_net180;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
   logic s_axi_arvalid = 0, s_axi_rready = 1;
   logic out_d0 = 0, out_d1 = 0, tri_d0 = 1, tri_d1 = 1;
   logic input_pair_clk_en = 0, output_pair_clk_en = 0;
   logic tristate_pair_clk_en = 0, set_reset_in = 0;
   logic reverse_force_in = 0, drv_en = 0, drv_val = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, in_q0, in_q1, pin_o, pin_oe, pin_i;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int errors = 0, n_checks = 0;

   // bench clock and two free-running cell clock nets
   always #12.5 aclk = ~aclk;
   always #303 clk_net0 = ~clk_net0;
   assign clk_net180 = ~clk_net0;

   io_cell_ddr_storage dut (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .clk_net0, .clk_net180, .out_d0,
      .out_d1, .tri_d0, .tri_d1, .in_q0, .in_q1, .input_pair_clk_en,
      .output_pair_clk_en, .tristate_pair_clk_en, .set_reset_in,
      .reverse_force_in, .pin_i, .pin_o, .pin_oe);
   io_pin_partner far_end (.pin_o, .pin_oe, .drv_en, .drv_val, .pin_i);

   // verdict and end of run
   task automatic final_report;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // comparisons and wait bounds
   task automatic chk(input string nm, input logic [31:0] s, e);
      n_checks++;
      if (s !== e) begin
         errors++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic c1(input string nm, input logic s, input logic e);
      chk(nm, {31'h0, s}, {31'h0, e});
   endtask
   task automatic bound(input int n, input int lim);
      if (n >= lim) begin
         errors++;
         $display("BAD wait exp done got timeout");
         final_report;
      end
   endtask

   // bus write: address and data offered together, released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
         input logic [1:0] er);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
      end while (s_axi_bvalid !== 1'b1 && n < 50);
      bound(n, 50);
      chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
   endtask

   // bus read; data compared only on an okay answer
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
         input logic [1:0] er);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      bound(n, 50);
      chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
      if (er === `RESP_OKAY) chk("rdata", s_axi_rdata, e);
   endtask

   // wait for a fresh level v of clk_net0, then k cycles
   task automatic at_net(input logic v, input int k);
      int n;
      for (n = 0; n < 40 && clk_net0 === v; n++) @(posedge aclk);
      bound(n, 40);
      for (n = 0; n < 40 && clk_net0 !== v; n++) @(posedge aclk);
      bound(n, 40);
      repeat (k) @(posedge aclk);
   endtask

   // reset values, unmapped places, self-clearing init, attribute storage
   task automatic t_regs;
      int i;
      for (i = 0; i < 8; i++)
         rd(8'(4 * i), 32'h0, `RESP_OKAY);
      rd(8'h24, 32'h0, `RESP_SLVERR);
      wr(8'h28, 32'h1, `RESP_SLVERR);
      wr(`ADDR_STATUS, 32'hffff_ffff, `RESP_OKAY);
      wr(`ADDR_CTRL, 32'h7ff, `RESP_OKAY);
      rd(`ADDR_CTRL, 32'h73f, `RESP_OKAY);
      wr(`ADDR_CTRL, 32'h0, `RESP_OKAY);
      wr(`ADDR_POL, 32'h1f, `RESP_OKAY);
      rd(`ADDR_POL, 32'h1f, `RESP_OKAY);
      wr(`ADDR_POL, 32'h0, `RESP_OKAY);
      wr(8'h0c, 32'h1f, `RESP_OKAY);
      rd(8'h0c, 32'h1f, `RESP_OKAY);
      rd(`ADDR_ELEM_BASE, 32'h0, `RESP_OKAY);
      wr(8'h0c, 32'h0, `RESP_OKAY);
   endtask

   // single rate paths, then ddr input pair; output enable input low but unused
   task automatic t_sdr;
      drv_en <= 1'b1;
      drv_val <= 1'b1;
      out_d0 <= 1'b1;
      at_net(1'b1, 7);
      at_net(1'b1, 7);
      c1("in_q0", in_q0, 1'b1);
      c1("in_q1", in_q1, 1'b1);
      c1("pin_oe off", pin_oe, 1'b0);
      c1("pin_o", pin_o, 1'b1);
      wr(`ADDR_CTRL, 32'h2, `RESP_OKAY);
      at_net(1'b1, 7);
      drv_val <= 1'b0;
      at_net(1'b0, 7);
      c1("in_q0 ddr", in_q0, 1'b1);
      c1("in_q1 ddr", in_q1, 1'b0);
      wr(`ADDR_CTRL, 32'h0, `RESP_OKAY);
      drv_en <= 1'b0;
      tri_d0 <= 1'b0;
      at_net(1'b1, 7);
      c1("pin_oe on", pin_oe, 1'b1);
   endtask

   // double rate output and tri-state, then clock mirror
   task automatic t_ddr;
      int i;
      logic [31:0] ctl [3] = '{32'hc, 32'hc, 32'h14};
      logic [3:0] din [3] = '{4'h9, 4'h6, 4'h0};
      logic [3:0] ex [3] = '{4'ha, 4'h5, 4'hb};
      for (i = 0; i < 3; i++) begin
         wr(`ADDR_CTRL, ctl[i], `RESP_OKAY);
         {out_d0, out_d1, tri_d0, tri_d1} <= din[i];
         at_net(1'b1, 7);
         at_net(1'b1, 7);
         c1("pin_o hi", pin_o, ex[i][3]);
         c1("pin_oe hi", pin_oe, ex[i][1]);
         at_net(1'b0, 7);
         c1("pin_o lo", pin_o, ex[i][2]);
         c1("pin_oe lo", pin_oe, ex[i][0]);
      end
      wr(`ADDR_CTRL, 32'h0, `RESP_OKAY);
   endtask

   // output pair enable in use, then inverted
   task automatic t_en;
      out_d0 <= 1'b0;
      at_net(1'b1, 7);
      wr(`ADDR_CTRL, 32'h200, `RESP_OKAY);
      out_d0 <= 1'b1;
      at_net(1'b1, 7);
      c1("out_ce held", pin_o, 1'b0);
      wr(`ADDR_POL, 32'h2, `RESP_OKAY);
      at_net(1'b1, 7);
      c1("out_ce inverted", pin_o, 1'b1);
      wr(`ADDR_POL, 32'h0, `RESP_OKAY);
      wr(`ADDR_CTRL, 32'h0, `RESP_OKAY);
   endtask

   // set/reset and reverse on element 2, async and sync, both values
   task automatic t_force;
      int j;
      logic sy, fh, sr, rv, e;
      for (j = 0; j < 12; j++) begin
         sy = (j >= 6);
         fh = ((j / 3) % 2) == 1;
         sr = (j % 3) != 1;
         rv = (j % 3) != 0;
         e = (sr && !rv) ? fh : ((rv && !sr) ? !fh : 1'b0);
         wr(`ADDR_CTRL, {31'h0, sy}, `RESP_OKAY);
         wr(8'h10, {27'h0, 2'b11, 1'b0, fh, 1'b0}, `RESP_OKAY);
         out_d0 <= !e;
         at_net(1'b1, 7);
         set_reset_in <= sr;
         reverse_force_in <= rv;
         repeat (3) @(posedge aclk);
         c1("async force", pin_o, sy ? !e : e);
         if (sy) begin
            at_net(1'b1, 7);
            c1("sync force", pin_o, e);
         end
         set_reset_in <= 1'b0;
         reverse_force_in <= 1'b0;
      end
      wr(`ADDR_CTRL, 32'h0, `RESP_OKAY);
      wr(8'h10, 32'h2, `RESP_OKAY);
      out_d0 <= 1'b0;
      set_reset_in <= 1'b1;
      at_net(1'b1, 7);
      c1("no forcing", pin_o, 1'b0);
      set_reset_in <= 1'b0;
      wr(8'h10, 32'h0, `RESP_OKAY);
   endtask

   // init pulse loads element 4 with one while its pair is disabled
   task automatic t_init;
      tri_d0 <= 1'b0;
      at_net(1'b1, 7);
      wr(8'h18, 32'h4, `RESP_OKAY);
      wr(`ADDR_CTRL, 32'h440, `RESP_OKAY);
      at_net(1'b1, 7);
      c1("init one", pin_oe, 1'b0);
      rd(`ADDR_CTRL, 32'h400, `RESP_OKAY);
      wr(`ADDR_CTRL, 32'h0, `RESP_OKAY);
      wr(8'h18, 32'h0, `RESP_OKAY);
   endtask

   // element 0 as latch: follows pin while net0 high, holds while low
   task automatic t_latch;
      tri_d0 <= 1'b1;
      drv_en <= 1'b1;
      drv_val <= 1'b0;
      wr(`ADDR_ELEM_BASE, 32'h1, `RESP_OKAY);
      at_net(1'b1, 4);
      drv_val <= 1'b1;
      repeat (5) @(posedge aclk);
      c1("latch open", in_q0, 1'b1);
      at_net(1'b0, 4);
      drv_val <= 1'b0;
      repeat (5) @(posedge aclk);
      c1("latch shut", in_q0, 1'b1);
      wr(`ADDR_ELEM_BASE, 32'h0, `RESP_OKAY);
   endtask

   // main sequence
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_regs;
      t_sdr;
      t_ddr;
      t_en;
      t_force;
      t_init;
      t_latch;
      final_report;
   end
endmodule // io_cell_ddr_storage_tb_top
